// ===== core/lnc_link_engine.sv
// credit, greeting and transmit spacing for one link end
`timescale 1ns/100ps
`default_nettype none
module lnc_link_engine
	import lnc_pkg::*;
(
	input  wire logic          i_mclk,
	input  wire logic          i_reset,
	input  wire logic          i_enable,
	input  wire logic          i_greet,
	input  wire logic          i_rx_rst,
	input  wire lnc_link_cfg_t i_cfg,
	input  wire lnc_link_ev_t  i_ev,
	output var  lnc_link_st_t  o_st
);
	typedef struct packed {
		lnc_link_st_t   st;
		logic [GAP_W:0] cnt;
	} lnc_eng_t;

	lnc_eng_t s_r;
	lnc_eng_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.st.tx_go = 1'b0;
		s_nxt.st.greet = 1'b0;
		s_nxt.st.rx_restart = 1'b0;
		if (s_r.cnt != '0)
			s_nxt.cnt = s_r.cnt - 1'b1;
		// clears first so that a same-cycle event still sets the flag
		if (i_rx_rst)
		begin
			s_nxt.st.rx_restart = 1'b1;
			s_nxt.st.err = 1'b0;
		end
		if (i_greet)
		begin
			s_nxt.st.held = 1'b0;
			s_nxt.st.greet = 1'b1;
		end
		if (i_ev.rx_fault)
			s_nxt.st.err = 1'b1;
		if (i_ev.credit_out)
			s_nxt.st.issued = 1'b1;
		if (i_ev.credit_in)
			s_nxt.st.held = 1'b1;
		// a held request is granted each time the counter is zero; spacing counter holds off the next
		if (i_ev.tx_req && s_r.st.held && s_r.cnt == '0)
		begin
			s_nxt.st.tx_go = 1'b1;
			s_nxt.cnt = {1'b0, (i_ev.tx_last ? i_cfg.tok_gap : i_cfg.sym_gap)} + 1'b1;
		end
		if (!i_enable)
			s_nxt = '0;
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign o_st = s_r.st;

	// checking helpers: idle cycles since last grant and spacing it demanded
	logic [GAP_W+1:0] since_r;
	logic [GAP_W:0]   need_r;
	logic             seen_r;
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			since_r <= '0;
			need_r <= '0;
			seen_r <= 1'b0;
		end
		else
		begin
			since_r <= s_r.st.tx_go ? '0 : (since_r + (since_r[GAP_W+1] ? 1'b0 : 1'b1));
			// spacing owed by a grant, taken while that grant stands
			if (s_r.st.tx_go)
			begin
				need_r <= s_r.cnt;
				seen_r <= 1'b1;
			end
			if (!i_enable)
				seen_r <= 1'b0;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	sequence greet_req;
		i_greet && !i_ev.credit_in && i_enable;
	endsequence
	sequence greet_done;
		!o_st.held && o_st.greet;
	endsequence

	a_credit_gate: assert property (o_st.tx_go |-> $past(o_st.held))
		else $error("grant issued without held credit");
	a_gap_spacing: assert property (o_st.tx_go && seen_r |-> since_r >= {1'b0, need_r})
		else $error("grants closer than programmed gap");
	a_greet_clear: assert property (greet_req |=> greet_done)
		else $error("greeting did not drop credit");
	a_rx_restart: assert property ((i_rx_rst && i_enable) ##1 !i_rx_rst |-> o_st.rx_restart ##1 !o_st.rx_restart)
		else $error("receiver restart not a single pulse");
endmodule : lnc_link_engine
`default_nettype wire

// ===== core/lnc_pkg.sv
// constants and types for the link and node configuration bank
package lnc_pkg;
	localparam int         GAP_W      = 11;
	localparam int         LINK_REGS  = 9;
	localparam int         NUM_STATIC = 8;
	localparam logic [7:0] ADR_LINK0  = 8'h80;
	localparam logic [7:0] ADR_STAT0  = 8'hA0;
	localparam logic [7:0] ADR_ID     = 8'h00;
	localparam logic [7:0] ADR_SETUP  = 8'h04;
	localparam logic [7:0] ADR_NODEID = 8'h05;
	localparam logic [7:0] ADR_MHZ    = 8'h51;
	localparam logic [7:0] ADR_ULINK  = 8'h80;
	localparam int B_EN    = 31;
	localparam int B_WIDE  = 30;
	localparam int B_ERR   = 27;
	localparam int B_ISS   = 26;
	localparam int B_HELD  = 25;
	localparam int B_GREET = 24;
	localparam int B_RXRST = 23;
	localparam int SYM_LO  = 11;
	localparam int TOK_LO  = 0;
	localparam int B_LOCK  = 31;
	localparam int B_HDR   = 0;
	localparam int B_STEN  = 31;
	localparam int CHAN_W  = 5;
	localparam int ID_CHIP = 24;
	localparam int ID_REV  = 8;
	localparam int ID_VER  = 0;
	localparam logic [GAP_W-1:0] ULINK_GAP_RST = 11'h001;
	localparam logic [6:0]       MHZ_RST       = 7'h19;
	localparam logic [31:0]      MHZ_MIN       = 32'h0000_0005;
	localparam logic [31:0]      MHZ_MAX       = 32'h0000_0064;
	// letter index (A=0 .. H=7) served by each static register, in address order
	localparam logic [2:0] STATIC_LINK [NUM_STATIC] = '{3'h2, 3'h3, 3'h0, 3'h1, 3'h6, 3'h7, 3'h4, 3'h5};

	typedef struct packed {
		logic tx_req;
		logic tx_last;
		logic credit_in;
		logic credit_out;
		logic rx_fault;
	} lnc_link_ev_t;

	typedef struct packed {
		logic tx_go;
		logic greet;
		logic rx_restart;
		logic err;
		logic issued;
		logic held;
	} lnc_link_st_t;

	typedef struct packed {
		logic             en;
		logic             wide;
		logic [GAP_W-1:0] sym_gap;
		logic [GAP_W-1:0] tok_gap;
	} lnc_link_cfg_t;

	typedef struct packed {
		logic              en;
		logic [CHAN_W-1:0] chan;
	} lnc_static_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        usb;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} lnc_cfg_req_t;

	typedef struct packed {
		logic        done;
		logic        nack;
		logic [31:0] rdata;
	} lnc_cfg_rsp_t;
endpackage : lnc_pkg

// ===== core/lnc_regs.sv
// link and node configuration register bank with its link ends
`timescale 1ns/100ps
`default_nettype none
module lnc_regs
	import lnc_pkg::*;
#(
	parameter int         NUM_LINKS = 8,
	parameter logic [7:0] CHIP_ID   = 8'h5A, // arbitrary value
	parameter logic [7:0] BLK_REV   = 8'h11, // arbitrary value
	parameter logic [7:0] BLK_VER   = 8'h22  // arbitrary value
)
(
	input  wire logic         i_mclk,
	input  wire logic         i_reset,
	input  wire lnc_cfg_req_t i_cfg,
	output var  lnc_cfg_rsp_t o_cfg,
	input  wire lnc_link_ev_t i_ev [NUM_LINKS+1],
	output var  lnc_link_st_t o_link [NUM_LINKS+1],
	output var  logic         o_link_en [NUM_LINKS],
	output var  logic         o_link_wide [NUM_LINKS],
	output var  lnc_static_t  o_static [NUM_STATIC],
	output var  logic         o_header_1b,
	output var  logic         o_locked,
	output var  logic [15:0]  o_node_id,
	output var  logic [6:0]   o_sysclk_mhz
);
	if (NUM_LINKS < 1 || NUM_LINKS > LINK_REGS)
	begin : g_bad_links
		$error("NUM_LINKS out of range");
	end

	typedef struct packed {
		lnc_link_cfg_t [NUM_LINKS-1:0]  ext;
		lnc_link_cfg_t                  usb;
		lnc_static_t [NUM_STATIC-1:0]   stat;
		logic                           lock;
		logic                           hdr1;
		logic [15:0]                    node_id;
		logic [6:0]                     mhz;
		lnc_cfg_rsp_t                   rsp;
		logic [NUM_LINKS:0]             greet;
		logic [NUM_LINKS:0]             rxrst;
	} lnc_regs_t;

	lnc_regs_t    s_r;
	lnc_regs_t    s_nxt;
	lnc_link_st_t st_w [NUM_LINKS+1];

	// status word shared by the external links and the node link
	function automatic logic [31:0] link_word(input lnc_link_cfg_t c, input lnc_link_st_t st,
		input logic ext);
		logic [31:0] w;
		w = '0;
		if (ext)
		begin
			w[B_EN] = c.en;
			w[B_WIDE] = c.wide;
		end
		w[B_ERR] = st.err;
		w[B_ISS] = st.issued;
		w[B_HELD] = st.held;
		w[SYM_LO +: GAP_W] = c.sym_gap;
		w[TOK_LO +: GAP_W] = c.tok_gap;
		return w;
	endfunction : link_word

	// gap fields of a link word write; the caller takes the one-shot commands
	function automatic lnc_link_cfg_t link_gaps(input lnc_link_cfg_t c, input logic [31:0] d);
		lnc_link_cfg_t r;
		r = c;
		r.sym_gap = d[SYM_LO +: GAP_W];
		r.tok_gap = d[TOK_LO +: GAP_W];
		return r;
	endfunction : link_gaps

	always_comb
	begin
		logic hit;
		hit = 1'b0;
		s_nxt = s_r;
		s_nxt.rsp = '0;
		s_nxt.greet = '0;
		s_nxt.rxrst = '0;
		if (i_cfg.valid)
		begin
			s_nxt.rsp.done = 1'b1;
			if (!i_cfg.usb)
			begin
				for (int k = 0; k < NUM_LINKS; k++)
				begin
					if (i_cfg.addr == ADR_LINK0 + 8'(k))
					begin
						hit = 1'b1;
						s_nxt.rsp.rdata = link_word(s_r.ext[k], st_w[k], 1'b1);
						if (i_cfg.write)
						begin
							s_nxt.ext[k] = link_gaps(s_r.ext[k], i_cfg.wdata);
							s_nxt.ext[k].en = i_cfg.wdata[B_EN];
							s_nxt.ext[k].wide = i_cfg.wdata[B_WIDE];
							s_nxt.greet[k] = i_cfg.wdata[B_GREET];
							s_nxt.rxrst[k] = i_cfg.wdata[B_RXRST];
						end
					end
				end
				for (int k = 0; k < NUM_STATIC; k++)
				begin
					if (i_cfg.addr == ADR_STAT0 + 8'(k))
					begin
						hit = 1'b1;
						s_nxt.rsp.rdata[B_STEN] = s_r.stat[k].en;
						s_nxt.rsp.rdata[CHAN_W-1:0] = s_r.stat[k].chan;
						if (i_cfg.write)
						begin
							s_nxt.stat[k].en = i_cfg.wdata[B_STEN];
							s_nxt.stat[k].chan = i_cfg.wdata[CHAN_W-1:0];
						end
					end
				end
				s_nxt.rsp.nack = !hit;
			end
			else
			begin
				unique case (i_cfg.addr)
					ADR_ID:
					begin
						s_nxt.rsp.rdata[ID_CHIP +: 8] = CHIP_ID;
						s_nxt.rsp.rdata[ID_REV +: 8] = BLK_REV;
						s_nxt.rsp.rdata[ID_VER +: 8] = BLK_VER;
						s_nxt.rsp.nack = i_cfg.write;
					end
					ADR_SETUP:
					begin
						s_nxt.rsp.rdata[B_LOCK] = s_r.lock;
						s_nxt.rsp.rdata[B_HDR] = s_r.hdr1;
						if (i_cfg.write && !s_r.lock)
						begin
							s_nxt.lock = i_cfg.wdata[B_LOCK];
							s_nxt.hdr1 = i_cfg.wdata[B_HDR];
						end
					end
					ADR_NODEID:
					begin
						s_nxt.rsp.rdata[15:0] = s_r.node_id;
						if (i_cfg.write)
							s_nxt.node_id = i_cfg.wdata[15:0];
					end
					ADR_MHZ:
					begin
						s_nxt.rsp.rdata[6:0] = s_r.mhz;
						if (i_cfg.write)
						begin
							if (i_cfg.wdata >= MHZ_MIN && i_cfg.wdata <= MHZ_MAX)
								s_nxt.mhz = i_cfg.wdata[6:0];
							else
								s_nxt.rsp.nack = 1'b1;
						end
					end
					ADR_ULINK:
					begin
						s_nxt.rsp.rdata = link_word(s_r.usb, st_w[NUM_LINKS], 1'b0);
						if (i_cfg.write && !s_r.lock)
						begin
							s_nxt.usb = link_gaps(s_r.usb, i_cfg.wdata);
							s_nxt.greet[NUM_LINKS] = i_cfg.wdata[B_GREET];
							s_nxt.rxrst[NUM_LINKS] = i_cfg.wdata[B_RXRST];
						end
					end
					default:
						s_nxt.rsp.nack = 1'b1;
				endcase
			end
			if (!i_cfg.write && s_nxt.rsp.nack)
				s_nxt.rsp.rdata = '0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			s_r <= '0;
			s_r.usb.en <= 1'b1;
			s_r.usb.sym_gap <= ULINK_GAP_RST;
			s_r.usb.tok_gap <= ULINK_GAP_RST;
			s_r.mhz <= MHZ_RST;
		end
		else
			s_r <= s_nxt;
	end

	for (genvar k = 0; k <= NUM_LINKS; k++)
	begin : g_link
		lnc_link_cfg_t cfg_w;
		// the last engine serves the node link, which has no external word
		if (k < NUM_LINKS)
		begin : g_ext
			assign cfg_w = s_r.ext[k];
			assign o_link_en[k] = s_r.ext[k].en;
			assign o_link_wide[k] = s_r.ext[k].wide;

			sequence link_wr;
				i_cfg.valid && i_cfg.write && !i_cfg.usb && i_cfg.addr == ADR_LINK0 + 8'(k);
			endsequence

			a_link_enable: assert property (@(posedge i_mclk) disable iff (i_reset)
				link_wr |=> o_link_en[k] == $past(i_cfg.wdata[B_EN])
				&& o_link_wide[k] == $past(i_cfg.wdata[B_WIDE]))
				else $error("link enable or wire mode not stored");
			a_link_gaps: assert property (@(posedge i_mclk) disable iff (i_reset)
				link_wr |=> s_r.ext[k].sym_gap == $past(i_cfg.wdata[SYM_LO +: GAP_W])
				&& s_r.ext[k].tok_gap == $past(i_cfg.wdata[TOK_LO +: GAP_W]))
				else $error("link gap fields not stored");
			a_link_cmds: assert property (@(posedge i_mclk) disable iff (i_reset)
				link_wr |=> s_r.greet[k] == $past(i_cfg.wdata[B_GREET])
				&& s_r.rxrst[k] == $past(i_cfg.wdata[B_RXRST]))
				else $error("link command bits not passed on");
			a_link_reset: assert property (@(posedge i_mclk) disable iff (i_reset)
				$past(i_reset) |-> !o_link_en[k] && !o_link_wide[k])
				else $error("link not disabled after reset");
		end
		else
		begin : g_node
			assign cfg_w = s_r.usb;
		end
		lnc_link_engine u_eng (
			.i_mclk   (i_mclk),
			.i_reset  (i_reset),
			.i_enable (cfg_w.en),
			.i_greet  (s_r.greet[k]),
			.i_rx_rst (s_r.rxrst[k]),
			.i_cfg    (cfg_w),
			.i_ev     (i_ev[k]),
			.o_st     (st_w[k])
		);
		assign o_link[k] = st_w[k];
	end

	for (genvar k = 0; k < NUM_STATIC; k++)
	begin : g_static
		assign o_static[STATIC_LINK[k]] = s_r.stat[k];

		sequence stat_wr;
			i_cfg.valid && i_cfg.write && !i_cfg.usb && i_cfg.addr == ADR_STAT0 + 8'(k);
		endsequence

		a_static_map: assert property (@(posedge i_mclk) disable iff (i_reset)
			stat_wr |=> o_static[STATIC_LINK[k]].en == $past(i_cfg.wdata[B_STEN])
			&& o_static[STATIC_LINK[k]].chan == $past(i_cfg.wdata[CHAN_W-1:0]))
			else $error("static register landed on wrong link");
		a_static_reset: assert property (@(posedge i_mclk) disable iff (i_reset)
			$past(i_reset) |-> o_static[STATIC_LINK[k]] == '0)
			else $error("static forwarding not cleared by reset");
	end

	assign o_cfg = s_r.rsp;
	assign o_header_1b = s_r.hdr1;
	assign o_locked = s_r.lock;
	assign o_node_id = s_r.node_id;
	assign o_sysclk_mhz = s_r.mhz;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_reset);

	sequence mhz_wr;
		i_cfg.valid && i_cfg.write && i_cfg.usb && i_cfg.addr == ADR_MHZ;
	endsequence
	sequence setup_wr;
		i_cfg.valid && i_cfg.write && i_cfg.usb && i_cfg.addr == ADR_SETUP;
	endsequence

	a_lock_sticky: assert property (o_locked |=> o_locked)
		else $error("lock bit fell without reset");
	a_lock_blocks: assert property (o_locked and setup_wr |=> $stable(o_header_1b) && !o_cfg.nack)
		else $error("locked setup register changed");
	a_mhz_refuse: assert property (mhz_wr ##0 (i_cfg.wdata > MHZ_MAX || i_cfg.wdata < MHZ_MIN)
		|=> o_cfg.done && o_cfg.nack && $stable(o_sysclk_mhz))
		else $error("out of range clock write not refused");
	a_mhz_take: assert property (mhz_wr ##0 (i_cfg.wdata <= MHZ_MAX && i_cfg.wdata >= MHZ_MIN)
		|=> !o_cfg.nack && o_sysclk_mhz == $past(i_cfg.wdata[6:0]))
		else $error("valid clock write not stored");
	a_reset_vals: assert property ($past(i_reset) |-> o_sysclk_mhz == MHZ_RST && !o_locked
		&& s_r.usb.sym_gap == ULINK_GAP_RST && s_r.usb.tok_gap == ULINK_GAP_RST)
		else $error("wrong values after reset");

	sequence nodeid_wr;
		i_cfg.valid && i_cfg.write && i_cfg.usb && i_cfg.addr == ADR_NODEID;
	endsequence
	sequence ulink_wr;
		i_cfg.valid && i_cfg.write && i_cfg.usb && i_cfg.addr == ADR_ULINK;
	endsequence
	sequence id_acc;
		i_cfg.valid && i_cfg.usb && i_cfg.addr == ADR_ID;
	endsequence

	// every request gets exactly one answer, on the next edge
	a_cfg_answer: assert property (i_cfg.valid |=> o_cfg.done)
		else $error("request not answered next cycle");
	a_cfg_quiet: assert property (!i_cfg.valid |=> !o_cfg.done && !o_cfg.nack)
		else $error("answer without a request");
	a_hdr_write: assert property (setup_wr ##0 !o_locked |=> o_header_1b == $past(i_cfg.wdata[B_HDR]))
		else $error("header mode not stored");
	a_lock_set: assert property (setup_wr ##0 (!o_locked && i_cfg.wdata[B_LOCK]) |=> o_locked)
		else $error("lock bit not set by write");
	a_ulink_locked: assert property (ulink_wr ##0 o_locked
		|=> $stable(s_r.usb) && !s_r.greet[NUM_LINKS] && !s_r.rxrst[NUM_LINKS] && !o_cfg.nack)
		else $error("locked node link word changed");
	a_nodeid_write: assert property (nodeid_wr |=> o_node_id == $past(i_cfg.wdata[15:0]))
		else $error("node identifier not stored");
	a_id_read: assert property (id_acc ##0 !i_cfg.write
		|=> !o_cfg.nack && o_cfg.rdata[ID_CHIP +: 8] == CHIP_ID
		&& o_cfg.rdata[ID_REV +: 8] == BLK_REV && o_cfg.rdata[ID_VER +: 8] == BLK_VER)
		else $error("identification word wrong");
	a_id_refuse: assert property (id_acc ##0 i_cfg.write |=> o_cfg.nack)
		else $error("write to identification word accepted");
	a_wo_read_zero: assert property (i_cfg.valid && !i_cfg.usb && !i_cfg.write
		|=> !o_cfg.rdata[B_GREET] && !o_cfg.rdata[B_RXRST])
		else $error("write-only command bits read back");
	a_mhz_range: assert property (o_sysclk_mhz >= MHZ_MIN[6:0] && o_sysclk_mhz <= MHZ_MAX[6:0])
		else $error("clock frequency outside accepted range");
	a_node_reset: assert property ($past(i_reset) |-> !o_header_1b && o_node_id == '0)
		else $error("node setup not cleared by reset");
	a_credit_reset: assert property ($past(i_reset)
		|-> !o_link[NUM_LINKS].held && !o_link[NUM_LINKS].issued && !o_link[0].held && !o_link[0].issued)
		else $error("credit flags set after reset");
endmodule : lnc_regs
`default_nettype wire

// ===== testbench/lnc_link_peer.sv
// remote link end model: credit, faults and transmit requests
`timescale 1ns/100ps
`default_nettype none
module lnc_link_peer
	import lnc_pkg::*;
(
	input  wire logic         i_mclk,
	input  wire lnc_link_ev_t i_cmd,
	input  wire lnc_link_st_t i_st,
	output var  lnc_link_ev_t o_ev,
	output var  int           o_grants,
	output var  int           o_gap
);
	int cyc;

	initial
	begin
		o_ev = '0;
		o_grants = 0;
		o_gap = 0;
		cyc = 0;
	end

	// command passed on at each falling edge, gap measured between grants
	always @(negedge i_mclk)
	begin
		o_ev <= i_cmd;
		if (i_st.tx_go === 1'b1)
		begin
			o_grants <= o_grants + 1;
			o_gap <= cyc;
			cyc <= 1;
		end
		else
			cyc <= cyc + 1;
	end
endmodule : lnc_link_peer
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the link and node configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb;
	import lnc_pkg::*;
	logic         i_mclk = 1'b0;
	logic         i_reset = 1'b1;
	lnc_cfg_req_t req = '0;
	lnc_cfg_rsp_t rsp;
	lnc_link_ev_t cmd [9];
	lnc_link_ev_t ev [9];
	lnc_link_st_t st [9];
	logic         en [8];
	logic         wide [8];
	lnc_static_t  stat [8];
	logic         hdr;
	logic         lck;
	logic [15:0]  nid;
	logic [6:0]   mhz;
	int           gr [9];
	int           gp [9];
	int           n_errors = 0;
	int           checks_done = 0;
	logic [31:0]  rd;
	logic [31:0]  mv [5] = '{32'h0000_0004, 32'h0000_0065, 32'h0000_0005, 32'h0000_0064, 32'h8000_0032};
	logic         mn [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	logic [31:0]  mr [5] = '{32'h0000_0019, 32'h0000_0019, 32'h0000_0005, 32'h0000_0064, 32'h0000_0064};

	always #2 i_mclk = ~i_mclk;

	lnc_regs #(.NUM_LINKS(8), .CHIP_ID(8'h3C), .BLK_REV(8'h4B), .BLK_VER(8'h6D)) dut (
		.i_mclk(i_mclk), .i_reset(i_reset), .i_cfg(req), .o_cfg(rsp), .i_ev(ev), .o_link(st),
		.o_link_en(en), .o_link_wide(wide), .o_static(stat), .o_header_1b(hdr), .o_locked(lck),
		.o_node_id(nid), .o_sysclk_mhz(mhz));

	for (genvar k = 0; k < 9; k++)
	begin : g_peer
		lnc_link_peer peer (.i_mclk(i_mclk), .i_cmd(cmd[k]), .i_st(st[k]), .o_ev(ev[k]),
			.o_grants(gr[k]), .o_gap(gp[k]));
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic acc(input logic usb, input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic enk);
		int i;
		@(negedge i_mclk);
		req <= {1'b1, wr, usb, a, wd};
		@(negedge i_mclk);
		req.valid <= 1'b0;
		for (i = 0; i < 4 && rsp.done !== 1'b1; i++)
			@(negedge i_mclk);
		rd = rsp.rdata;
		chk({31'h0000_0000, rsp.done}, 32'h0000_0001);
		chk({31'h0000_0000, rsp.nack}, {31'h0000_0000, enk});
	endtask : acc

	task automatic rdchk(input logic usb, input logic [7:0] a, input logic [31:0] exp);
		acc(usb, 1'b0, a, 32'h0000_0000, 1'b0);
		chk(rd, exp);
	endtask : rdchk

	task automatic pulse(input int k, input lnc_link_ev_t e);
		@(negedge i_mclk);
		cmd[k] <= e;
		@(negedge i_mclk);
		cmd[k] <= '0;
		repeat (3) @(negedge i_mclk);
	endtask : pulse

	task automatic wait_gr(input int k, input int n);
		int i;
		for (i = 0; i < 200 && gr[k] < n; i++)
			@(negedge i_mclk);
		chk(32'(gr[k]), 32'(n));
	endtask : wait_gr

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#100000;
		n_errors++;
		tally_and_finish();
	end

	initial
	begin
		for (int k = 0; k < 9; k++)
			cmd[k] = '0;
		repeat (16) @(negedge i_mclk);
		i_reset <= 1'b0;
		rdchk(1'b1, ADR_ID, 32'h3C00_4B6D);
		acc(1'b1, 1'b1, ADR_ID, 32'hFFFF_FFFF, 1'b1);
		rdchk(1'b1, ADR_SETUP, 32'h0000_0000);
		rdchk(1'b1, ADR_NODEID, 32'h0000_0000);
		rdchk(1'b1, ADR_MHZ, 32'h0000_0019);
		rdchk(1'b1, ADR_ULINK, 32'h0000_0801);
		rdchk(1'b0, ADR_LINK0, 32'h0000_0000);
		for (int k = 0; k < 8; k++)
		begin
			acc(1'b0, 1'b1, ADR_LINK0 + 8'(k), 32'hF040_1802, 1'b0);
			rdchk(1'b0, ADR_LINK0 + 8'(k), 32'hC000_1802);
			chk({30'h0000_0000, en[k], wide[k]}, 32'h0000_0003);
		end
		for (int i = 0; i < 8; i++)
		begin
			acc(1'b0, 1'b1, ADR_STAT0 + 8'(i), 32'hFFFF_FFE0 | 32'(i), 1'b0);
			rdchk(1'b0, ADR_STAT0 + 8'(i), 32'h8000_0000 | 32'(i));
			chk({26'h000_0000, stat[STATIC_LINK[i]]}, {26'h000_0000, 1'b1, 5'(i)});
		end
		acc(1'b1, 1'b1, ADR_NODEID, 32'hABCD_1234, 1'b0);
		rdchk(1'b1, ADR_NODEID, 32'h0000_1234);
		chk({16'h0000, nid}, 32'h0000_1234);
		for (int i = 0; i < 5; i++)
		begin
			acc(1'b1, 1'b1, ADR_MHZ, mv[i], mn[i]);
			rdchk(1'b1, ADR_MHZ, mr[i]);
			chk({25'h000_0000, mhz}, mr[i]);
		end
		acc(1'b1, 1'b0, 8'h10, 32'h0000_0000, 1'b1);
		acc(1'b0, 1'b0, 8'h90, 32'h0000_0000, 1'b1);
		pulse(0, 5'h04);
		pulse(0, 5'h02);
		pulse(0, 5'h01);
		rdchk(1'b0, ADR_LINK0, 32'hCE00_1802);
		acc(1'b0, 1'b1, ADR_LINK0, 32'hC080_1802, 1'b0);
		rdchk(1'b0, ADR_LINK0, 32'hC600_1802);
		@(negedge i_mclk);
		cmd[0] <= 5'h10;
		wait_gr(0, 2);
		chk(32'(gp[0]), 32'h0000_0005);
		cmd[0] <= 5'h18;
		wait_gr(0, 4);
		chk(32'(gp[0]), 32'h0000_0004);
		cmd[0] <= 5'h00;
		repeat (8) @(negedge i_mclk);
		acc(1'b0, 1'b1, ADR_LINK0, 32'hC100_1802, 1'b0);
		rdchk(1'b0, ADR_LINK0, 32'hC400_1802);
		cmd[0] <= 5'h10;
		repeat (20) @(negedge i_mclk);
		chk(32'(gr[0]), 32'(4));
		cmd[0] <= 5'h14;
		@(negedge i_mclk);
		cmd[0] <= 5'h10;
		wait_gr(0, 6);
		cmd[0] <= 5'h00;
		acc(1'b1, 1'b1, ADR_SETUP, 32'h8000_0001, 1'b0);
		chk({30'h0000_0000, lck, hdr}, 32'h0000_0003);
		acc(1'b1, 1'b1, ADR_SETUP, 32'h0000_0000, 1'b0);
		rdchk(1'b1, ADR_SETUP, 32'h8000_0001);
		acc(1'b1, 1'b1, ADR_ULINK, 32'h0000_0000, 1'b0);
		rdchk(1'b1, ADR_ULINK, 32'h0000_0801);
		acc(1'b0, 1'b1, ADR_LINK0, 32'h0000_0000, 1'b0);
		rdchk(1'b0, ADR_LINK0, 32'h0000_0000);
		chk({30'h0000_0000, en[0], wide[0]}, 32'h0000_0000);
		@(negedge i_mclk);
		i_reset <= 1'b1;
		repeat (4) @(negedge i_mclk);
		i_reset <= 1'b0;
		rdchk(1'b1, ADR_SETUP, 32'h0000_0000);
		rdchk(1'b1, ADR_MHZ, 32'h0000_0019);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
